// file: hw/rcd_defines.vh
`ifndef RCD_DEFINES_VH
`define RCD_DEFINES_VH

// byte addresses of the registers
`define RCD_ADDR_DATE     12'h000
`define RCD_ADDR_CTRL     12'h004
`define RCD_ADDR_W        12

// date field positions
`define RCD_YEAR_T_HI     31
`define RCD_YEAR_T_LO     28
`define RCD_YEAR_O_HI     27
`define RCD_YEAR_O_LO     24
`define RCD_MON_T_HI      23
`define RCD_MON_T_LO      20
`define RCD_MON_O_HI      19
`define RCD_MON_O_LO      16
`define RCD_DAY_T_HI      15
`define RCD_DAY_T_LO      12
`define RCD_DAY_O_HI      11
`define RCD_DAY_O_LO      8
`define RCD_WDAY_HI       3
`define RCD_WDAY_LO       0

// control register: write-enable bit position
`define RCD_WREN_BIT      3

// largest legal digit values
`define RCD_MAX_MON_T     4'h1
`define RCD_MAX_DIGIT     4'h9
`define RCD_MAX_DAY_T     4'h3
`define RCD_MAX_WDAY      4'h6

// reset contents
`define RCD_DATE_RESET    32'h0000_0000
`define RCD_ZERO32        32'h0000_0000
`define RCD_ZERO_NIB      4'h0

// bus responses
`define RCD_RESP_OKAY     2'h0
`define RCD_RESP_SLVERR   2'h2

`endif

// file: hw/rcd_date_store.v
`include "rcd_defines.vh"

module rcd_date_store (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        wr_en,
  input  wire [31:0] wr_data,
  input  wire [3:0]  wr_strb,
  output wire [31:0] date_word
);

  reg [3:0] year_tens_digit;
  reg [3:0] year_ones_digit;
  reg [3:0] month_tens_digit;
  reg [3:0] month_ones_digit;
  reg [3:0] day_tens_digit;
  reg [3:0] day_ones_digit;
  reg [3:0] weekday_digit;

  // low nibble of a byte lane, no legality check; an out-of-range digit is kept as written, software owns it
  function [3:0] rcd_lane;
    input [31:0] d;
    input [1:0]  lane;
    begin
      rcd_lane = d[lane*8 +: 4];
    end
  endfunction

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      year_tens_digit  <= `RCD_ZERO_NIB;
      year_ones_digit  <= `RCD_ZERO_NIB;
      month_tens_digit <= `RCD_ZERO_NIB;
      month_ones_digit <= `RCD_ZERO_NIB;
      day_tens_digit   <= `RCD_ZERO_NIB;
      day_ones_digit   <= `RCD_ZERO_NIB;
      weekday_digit    <= `RCD_ZERO_NIB;
    end
    else if (wr_en)
    begin
      if (wr_strb[3])
      begin
        year_tens_digit <= wr_data[`RCD_YEAR_T_HI:`RCD_YEAR_T_LO];
        year_ones_digit <= wr_data[`RCD_YEAR_O_HI:`RCD_YEAR_O_LO];
      end
      if (wr_strb[2])
      begin
        month_tens_digit <= wr_data[`RCD_MON_T_HI:`RCD_MON_T_LO];
        month_ones_digit <= wr_data[`RCD_MON_O_HI:`RCD_MON_O_LO];
      end
      if (wr_strb[1])
      begin
        day_tens_digit <= wr_data[`RCD_DAY_T_HI:`RCD_DAY_T_LO];
        day_ones_digit <= wr_data[`RCD_DAY_O_HI:`RCD_DAY_O_LO];
      end
      if (wr_strb[0])
        weekday_digit <= rcd_lane(wr_data, 2'd0);
    end
  end

  // bits 7:4 have no storage
  assign date_word = {year_tens_digit, year_ones_digit,
                      month_tens_digit, month_ones_digit,
                      day_tens_digit, day_ones_digit,
                      `RCD_ZERO_NIB, weekday_digit};

endmodule // rcd_date_store

// file: hw/rcd_calendar_date.v
// Chosen here: the placing of the registers and the AXI4-Lite slave port.

`include "rcd_defines.vh"

module rcd_calendar_date (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [11:0] s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg         date_legal
);

  ////////////////////////////////////////////////////////////////////////////
  // write channel capture

  reg  [11:0] aw_addr;
  reg         aw_held;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;
  reg         w_held;
  reg         clock_write_enable;
  wire [31:0] date_word;
  wire        wr_fire;
  wire        date_sel;
  wire        ctrl_sel;
  wire        date_wr;

  function rcd_legal;
    input [31:0] d;
    begin
      rcd_legal =
        (d[`RCD_YEAR_T_HI:`RCD_YEAR_T_LO] <= `RCD_MAX_DIGIT) &&
        (d[`RCD_YEAR_O_HI:`RCD_YEAR_O_LO] <= `RCD_MAX_DIGIT) &&
        (d[`RCD_MON_T_HI:`RCD_MON_T_LO] <= `RCD_MAX_MON_T) &&
        (d[`RCD_MON_O_HI:`RCD_MON_O_LO] <= `RCD_MAX_DIGIT) &&
        (d[`RCD_DAY_T_HI:`RCD_DAY_T_LO] <= `RCD_MAX_DAY_T) &&
        (d[`RCD_DAY_O_HI:`RCD_DAY_O_LO] <= `RCD_MAX_DIGIT) &&
        (d[`RCD_WDAY_HI:`RCD_WDAY_LO] <= `RCD_MAX_WDAY);
    end
  endfunction

  // decode shared by both channels
  function [1:0] rcd_decode;
    input [11:0] a;
    begin
      if ({a[11:2], 2'b00} == `RCD_ADDR_DATE)
        rcd_decode = 2'b01;
      else if ({a[11:2], 2'b00} == `RCD_ADDR_CTRL)
        rcd_decode = 2'b10;
      else
        rcd_decode = 2'b00;
    end
  endfunction

  assign wr_fire  = aw_held && w_held && !s_axi_bvalid;
  assign date_sel = rcd_decode(aw_addr) == 2'b01;
  assign ctrl_sel = rcd_decode(aw_addr) == 2'b10;
  assign date_wr  = wr_fire && date_sel && clock_write_enable;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_addr       <= `RCD_ADDR_DATE;
      aw_held       <= 1'b0;
      s_axi_awready <= 1'b0;
      w_data        <= `RCD_ZERO32;
      w_strb        <= 4'h0;
      w_held        <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RCD_RESP_OKAY;
      clock_write_enable <= 1'b0;
    end
    else
    begin
      // one write in flight; ready drops while a beat is held
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr <= s_axi_awaddr;
        aw_held <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        w_held <= 1'b1;
      end
      if (wr_fire)
      begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // a locked date write is dropped but still answered okay
        s_axi_bresp  <= (date_sel || ctrl_sel) ? `RCD_RESP_OKAY
                                               : `RCD_RESP_SLVERR;
        if (ctrl_sel && w_strb[0])
          clock_write_enable <= w_data[`RCD_WREN_BIT];
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  rcd_date_store u_store (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .wr_en     (date_wr),
    .wr_data   (w_data),
    .wr_strb   (w_strb),
    .date_word (date_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read channel

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= `RCD_ZERO32;
      s_axi_rresp   <= `RCD_RESP_OKAY;
      date_legal    <= 1'b0;
    end
    else
    begin
      date_legal    <= rcd_legal(date_word);
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        if (rcd_decode(s_axi_araddr) == 2'b01)
        begin
          // all fields latched on one edge
          s_axi_rdata <= date_word;
          s_axi_rresp <= `RCD_RESP_OKAY;
        end
        else if (rcd_decode(s_axi_araddr) == 2'b10)
        begin
          s_axi_rdata <= {28'h000_0000, clock_write_enable, 3'b000};
          s_axi_rresp <= `RCD_RESP_OKAY;
        end
        else
        begin
          s_axi_rdata <= `RCD_ZERO32;
          s_axi_rresp <= `RCD_RESP_SLVERR;
        end
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule // rcd_calendar_date

// file: testbench/rcd_calendar_date_sva.sv
`include "rcd_defines.vh"

module rcd_calendar_date_sva (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  default clocking dc @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // both halves of a write taken on one edge, nothing pending
  wire both_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
                 s_axi_wready && !s_axi_bvalid;
  wire ar_go   = s_axi_arvalid && s_axi_arready;
  //////////////////////////////////////////////////////////////////////
  rd_pad_zero_a:
    assert property (s_axi_rvalid |-> s_axi_rdata[7:4] == 4'h0)
      else $error("pad bits of read word not zero");
  rd_hold_a:
    assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read word changed before taken");
  rd_lat_a:
    assert property (ar_go |=> s_axi_rvalid)
      else $error("read answer late");
  ar_block_a:
    assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("address taken during pending read");
  rd_slverr_a:
    assert property (ar_go && s_axi_araddr[11:3] != 9'h000 |=>
      s_axi_rresp == `RCD_RESP_SLVERR && s_axi_rdata == `RCD_ZERO32)
      else $error("unmapped read not refused");
  wr_lat_a:
    // held beats fire one cycle after capture, answer lands the cycle after
    assert property (both_go |-> ##2 s_axi_bvalid)
      else $error("write answer late");
  wr_okay_a:
    assert property (both_go && s_axi_awaddr[11:3] == 9'h000 |-> ##2
      s_axi_bresp == `RCD_RESP_OKAY)
      else $error("mapped write not okay");
  b_hold_a:
    assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped early");
endmodule // rcd_calendar_date_sva

// file: testbench/tb.sv
`include "rcd_defines.vh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 0, aresetn = 0, date_legal;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd, d, exp_date = 0;
  logic [3:0]  s_axi_wstrb = 0, s;
  logic [2:0]  s_axi_awprot = 0, s_axi_arprot = 0;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready;
  logic        s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  int          fail_count = 0, n_compared = 0;
  int          sh[5] = '{20, 16, 12, 8, 0};
  logic [3:0]  mx[5] = '{4'h1, 4'h9, 4'h3, 4'h9, 4'h6};
  rcd_calendar_date rcd_calendar_date_inst (.*);
  always #5 aclk = ~aclk;
  //////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // bounded wait: a stuck handshake ends the run instead of hanging
  task automatic tick(inout int n);
    @(posedge aclk);
    n++;
    if (n > 50)
    begin
      fail_count++;
      $display("[ERR] handshake expected answer seen none");
      tally_and_finish;
    end
  endtask
  task automatic axi_wr(input [11:0] a, input [31:0] v, input [3:0] st,
                        input [1:0] er);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      tick(n);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    check("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask
  task automatic rd_chk(input [11:0] a, input [31:0] e, input [1:0] er);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      tick(n);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    check("rdata", e, s_axi_rdata);
    check("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask
  // byte lanes merge; the pad nibble never keeps what was written
  function automatic [31:0] merge(input [31:0] o, v, input [3:0] st);
    for (int i = 0; i < 4; i++)
      if (st[i]) o[8*i +: 8] = v[8*i +: 8];
    return o & 32'hffff_ff0f;
  endfunction
  function automatic [31:0] rand_date();
    return {4'($urandom % 10), 4'($urandom % 10), 4'($urandom % 2),
            4'($urandom % 10), 4'($urandom % 4), 4'($urandom % 10),
            4'($urandom), 4'($urandom % 7)};
  endfunction
  task automatic wr_rd(input [31:0] v, input [3:0] st, input logic ok);
    axi_wr(`RCD_ADDR_DATE, v, st, `RCD_RESP_OKAY);
    exp_date = merge(exp_date, v, st);
    rd_chk(`RCD_ADDR_DATE, exp_date, `RCD_RESP_OKAY);
    @(posedge aclk);
    check("legal", {31'h0, ok}, {31'h0, date_legal});
  endtask
  //////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(31));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_chk(`RCD_ADDR_DATE, exp_date, `RCD_RESP_OKAY);
    axi_wr(`RCD_ADDR_DATE, rand_date(), 4'hf, `RCD_RESP_OKAY);
    rd_chk(`RCD_ADDR_DATE, exp_date, `RCD_RESP_OKAY);
    axi_wr(`RCD_ADDR_CTRL, 32'h0000_0008, 4'h1, `RCD_RESP_OKAY);
    rd_chk(`RCD_ADDR_CTRL, 32'h0000_0008, `RCD_RESP_OKAY);
    repeat (24)
    begin
      s = ($urandom % 2) ? 4'hf : 4'($urandom);
      wr_rd(rand_date(), s, 1'b1);
    end
    foreach (sh[k])
      for (int b = 0; b < 2; b++)
      begin
        d = 32'h0000_0000;
        d[sh[k] +: 4] = mx[k] + 4'(b);
        wr_rd(d, 4'hf, b == 0);
      end
    axi_wr(12'h010, 32'hffff_ffff, 4'hf, `RCD_RESP_SLVERR);
    rd_chk(12'h010, 32'h0000_0000, `RCD_RESP_SLVERR);
    axi_wr(`RCD_ADDR_CTRL, 32'h0000_0000, 4'h1, `RCD_RESP_OKAY);
    axi_wr(`RCD_ADDR_DATE, ~exp_date, 4'hf, `RCD_RESP_OKAY);
    rd_chk(`RCD_ADDR_DATE, exp_date, `RCD_RESP_OKAY);
    tally_and_finish;
  end
endmodule // tb

bind rcd_calendar_date rcd_calendar_date_sva rcd_calendar_date_sva_inst (.*);
